// ### src/tca_pkg.sv
// Constants shared by the turns counter and angle readout block
package tca_pkg;
    // Register offsets on the serial register interface
    localparam logic [7:0] ROTATION_COUNT_WORD_ADDR = 8'h2C;
    localparam logic [7:0] POSITION_LOW_BITS_WORD_ADDR = 8'h2E;
    localparam logic [7:0] DAMPED_ANGLE_WORD_ADDR = 8'h30;
    localparam logic [7:0] FINE_ANGLE_WORD_ADDR = 8'h32;
    localparam logic [7:0] LOW_POWER_ANGLE_WORD_ADDR = 8'h34;
    // Identifier fields
    localparam logic [1:0] COUNT_WORD_ID = 2'h3;
    localparam logic [0:0] LOW_WORD_ID = 1'h1;
    localparam logic [0:0] ANGLE_WORD_ID = 1'h0;
    // Field positions
    localparam int COUNT_ID_MSB = 15;
    localparam int COUNT_ID_LSB = 14;
    localparam int SOURCE_BIT = 13;
    localparam int PARITY_BIT = 12;
    localparam int HELD_BIT = 14;
    localparam int FAULT_BIT = 14;
    localparam int SUPPLY_BIT = 13;
    localparam int OVERFLOW_WARN_BIT = 0;
    // Accumulated position: 9 turn bits above 12 angle bits
    localparam int POS_W = 21;
    localparam int ANGLE_W = 12;
    localparam int FINE_W = 15;
    localparam int EIGHTH_LSB = 9;
    localparam int HALF_LSB = 11;
    // Reset values
    localparam logic [POS_W-1:0] POS_RESET = 21'h000000;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Turns update period and the 135 degree warning limit (1536 of 4096)
    localparam int TURN_PERIOD_NS = 64000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int TURN_PERIOD_CYC = TURN_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [ANGLE_W-1:0] STEP_LIMIT = 12'h600;
endpackage

// ### src/tca_readout.sv
// Turns counter with snapshot of low bits and angle result words
//
// Summary of operation
// - Count word carries id 11 in bits 15:14; low-bits word carries 1 in bit 15.
// - Bit 12 of the count, low-bits, damped and low-power words makes the whole word odd parity.
// - Count word bits 11:0 hold signed turns since the power-up angle.
// - One count step is 180 or 45 degrees per resolution setting.
// - Up to 256 turns either way; range -512..511 or -2048..2047.
// - Overflow flag, warning bit 0, rises when rotation reaches +256 turns or passes -256 turns.
// - Eighth-turn mode puts position bits 20:9 into the count field.
// - Half-turn mode puts position bits 20:11, sign-extended, into the count field.
// - Remaining 11 or 9 low position bits appear in bits 10:0 of low word.
// - Low bits are captured when the count word is read.
// - Held bit 14 set after a count read, cleared when low word read.
// - Damped and low-power angle words bit 14 shows any unmasked error or warning.
// - Damped and low-power angle words bit 13 is the masked OR of both supply-low flags.
// - Damped angle word bits 11:0 give hysteresis angle, 360/4096 per count.
// - Fine angle word bits 14:0 give unrounded 15-bit angle, bit 15 zero.
// - Low-power word bits 11:0 give uncompensated zero-crossing angle.
// - Count word bit 13 names the path used for turn counting.
// - Counter updates every 64 us; step above 135 degrees raises a warning.
// - Overflow and step warnings stay latched until the host clears them.
`timescale 1ns/1ps

module tca_readout
    import tca_pkg::*;
#(
    parameter int TURN_PERIOD = TURN_PERIOD_CYC
) (
    input wire logic i_core_clk,                          // Core clock, 125 MHz
    input wire logic i_rst,                               // Synchronous reset, active high
    input wire logic i_rd_en,                             // Register read request
    input wire logic [7:0] i_rd_addr,                     // Register read offset
    output logic [15:0] o_rd_data,                        // Read data word
    output logic o_rd_valid,                              // Read data valid pulse
    input wire logic [ANGLE_W-1:0] i_damped_angle,        // Main path angle after hysteresis
    input wire logic [FINE_W-1:0] i_fine_angle,           // Compensated 15-bit angle
    input wire logic [ANGLE_W-1:0] i_low_power_path_angle, // Zero-crossing path angle
    input wire logic i_rotation_source_select,            // 1: main path feeds turns
    input wire logic i_eighth_turn_resolution,            // 1: 45 degree steps
    input wire logic i_other_fault,                       // Any other unmasked error or warning
    input wire logic i_overflow_mask,                     // Masks overflow from fault flag
    input wire logic i_step_warn_mask,                    // Masks step warning from fault flag
    input wire logic i_analog_supply_low,                 // Analog undervoltage pin
    input wire logic i_core_supply_low,                   // Digital undervoltage pin
    input wire logic i_analog_mask,                       // Masks analog undervoltage
    input wire logic i_core_mask,                         // Masks digital undervoltage
    input wire logic i_warn_clear,                        // Host clears latched warnings
    output logic o_rotation_overflow_flag,                // Latched overflow, warning bit 0
    output logic o_turns_step_warning,                    // Latched step warning
    output logic o_unmasked_fault_flag,                   // Combined fault summary
    output logic o_supply_low_flag                        // Masked undervoltage summary
);

    ////////////////////////////////////////////////////////////////////////////
    // Undervoltage pins cross into the core clock

    logic [1:0] supply_meta_ff;
    logic [1:0] supply_sync_ff;
    logic [1:0] nxt_supply_meta;
    logic [1:0] nxt_supply_sync;

    always_comb begin
        nxt_supply_meta = {i_analog_supply_low, i_core_supply_low};
        nxt_supply_sync = supply_meta_ff;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            supply_meta_ff <= 2'h0;
            supply_sync_ff <= 2'h0;
        end else begin
            supply_meta_ff <= nxt_supply_meta;
            supply_sync_ff <= nxt_supply_sync;
        end
    end

    logic supply_low_flag;
    logic unmasked_fault_flag;
    assign supply_low_flag = (supply_sync_ff[1] & ~i_analog_mask) | (supply_sync_ff[0] & ~i_core_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Turn accumulation

    logic [$clog2(TURN_PERIOD)-1:0] tick_cnt_ff;
    logic [$clog2(TURN_PERIOD)-1:0] nxt_tick_cnt;
    logic tick;
    logic started_ff;
    logic nxt_started;
    logic [ANGLE_W-1:0] last_angle_ff;
    logic [ANGLE_W-1:0] nxt_last_angle;
    logic [POS_W-1:0] pos_ff;
    logic [POS_W-1:0] nxt_pos;
    logic overflow_ff;
    logic nxt_overflow;
    logic step_warn_ff;
    logic nxt_step_warn;
    logic [ANGLE_W-1:0] turn_angle;
    logic [ANGLE_W-1:0] step;
    logic [ANGLE_W-1:0] step_mag;
    logic [POS_W:0] pos_sum;
    logic sum_over;

    assign tick = (tick_cnt_ff == ($clog2(TURN_PERIOD))'(TURN_PERIOD - 1));
    assign turn_angle = i_rotation_source_select ? i_damped_angle : i_low_power_path_angle;
    assign step = turn_angle - last_angle_ff;
    assign step_mag = step[ANGLE_W-1] ? (~step + 12'h001) : step;
    // Modulo difference keeps wrap through zero degrees a small step
    assign pos_sum = {pos_ff[POS_W-1], pos_ff} + {{(POS_W-ANGLE_W+1){step[ANGLE_W-1]}}, step};
    assign sum_over = pos_sum[POS_W] != pos_sum[POS_W-1];

    always_comb begin
        nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
        nxt_started = started_ff;
        nxt_last_angle = last_angle_ff;
        nxt_pos = pos_ff;
        nxt_overflow = overflow_ff & ~i_warn_clear;
        nxt_step_warn = step_warn_ff & ~i_warn_clear;
        if (tick) begin
            nxt_started = 1'b1;
            nxt_last_angle = turn_angle;
            if (started_ff) begin
                // Hold the last position rather than wrap so the count never jumps sign
                if (sum_over) begin
                    nxt_overflow = 1'b1;
                end else begin
                    nxt_pos = pos_sum[POS_W-1:0];
                end
                if (step_mag > STEP_LIMIT) begin
                    nxt_step_warn = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tick_cnt_ff <= '0;
            started_ff <= 1'b0;
            last_angle_ff <= '0;
            pos_ff <= POS_RESET;
            overflow_ff <= 1'b0;
            step_warn_ff <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            started_ff <= nxt_started;
            last_angle_ff <= nxt_last_angle;
            pos_ff <= nxt_pos;
            overflow_ff <= nxt_overflow;
            step_warn_ff <= nxt_step_warn;
        end
    end

    assign unmasked_fault_flag = i_other_fault | (overflow_ff & ~i_overflow_mask)
        | (step_warn_ff & ~i_step_warn_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Result words and register reads

    logic [ANGLE_W-1:0] count_field;
    logic [10:0] low_field;
    logic [10:0] held_low_ff;
    logic [10:0] nxt_held_low;
    logic held_ff;
    logic nxt_held;
    logic [15:0] rd_data_ff;
    logic [15:0] nxt_rd_data;
    logic rd_valid_ff;
    logic nxt_rd_valid;
    logic [15:0] raw_word;

    always_comb begin
        if (i_eighth_turn_resolution) begin
            count_field = pos_ff[POS_W-1:EIGHTH_LSB];
            low_field = {2'h0, pos_ff[EIGHTH_LSB-1:0]};
        end else begin
            count_field = {{2{pos_ff[POS_W-1]}}, pos_ff[POS_W-1:HALF_LSB]};
            low_field = pos_ff[HALF_LSB-1:0];
        end
    end

    function automatic logic [15:0] odd_fix(input logic [15:0] w);
        logic [15:0] r;
        r = w;
        r[PARITY_BIT] = ~(^{w[15:13], w[11:0]});
        return r;
    endfunction

    always_comb begin
        nxt_held_low = held_low_ff;
        nxt_held = held_ff;
        nxt_rd_valid = i_rd_en;
        nxt_rd_data = rd_data_ff;
        raw_word = WORD_RESET;
        if (i_rd_en) begin
            unique case (i_rd_addr)
                ROTATION_COUNT_WORD_ADDR: begin
                    raw_word = {COUNT_WORD_ID, i_rotation_source_select, 1'b0, count_field};
                    nxt_held_low = low_field;
                    nxt_held = 1'b1;
                end
                POSITION_LOW_BITS_WORD_ADDR: begin
                    // Live bits when no count read came first
                    raw_word = {LOW_WORD_ID, held_ff, 3'h0, held_ff ? held_low_ff : low_field};
                    nxt_held = 1'b0;
                end
                DAMPED_ANGLE_WORD_ADDR: begin
                    raw_word = {ANGLE_WORD_ID, unmasked_fault_flag, supply_low_flag, 1'b0, i_damped_angle};
                end
                FINE_ANGLE_WORD_ADDR: begin
                    raw_word = {1'b0, i_fine_angle};
                end
                LOW_POWER_ANGLE_WORD_ADDR: begin
                    raw_word = {ANGLE_WORD_ID, unmasked_fault_flag, supply_low_flag, 1'b0,
                        i_low_power_path_angle};
                end
                default: begin
                    raw_word = WORD_RESET;
                end
            endcase
            // Fine angle word and unmapped offsets have no parity bit; the other four words are forced odd
            if (i_rd_addr == FINE_ANGLE_WORD_ADDR || !(i_rd_addr inside {ROTATION_COUNT_WORD_ADDR,
                POSITION_LOW_BITS_WORD_ADDR, DAMPED_ANGLE_WORD_ADDR, LOW_POWER_ANGLE_WORD_ADDR})) begin
                nxt_rd_data = raw_word;
            end else begin
                nxt_rd_data = odd_fix(raw_word);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            held_low_ff <= 11'h000;
            held_ff <= 1'b0;
            rd_data_ff <= WORD_RESET;
            rd_valid_ff <= 1'b0;
        end else begin
            held_low_ff <= nxt_held_low;
            held_ff <= nxt_held;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    assign o_rd_data = rd_data_ff;
    assign o_rd_valid = rd_valid_ff;
    assign o_rotation_overflow_flag = overflow_ff;
    assign o_turns_step_warning = step_warn_ff;
    assign o_unmasked_fault_flag = unmasked_fault_flag;
    assign o_supply_low_flag = supply_low_flag;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence seq_count_read;
        i_rd_en && i_rd_addr == ROTATION_COUNT_WORD_ADDR;
    endsequence

    sequence seq_low_read;
        i_rd_en && i_rd_addr == POSITION_LOW_BITS_WORD_ADDR;
    endsequence

    AST_COUNT_ID: assert property (seq_count_read |=> o_rd_valid && o_rd_data[15:14] == 2'h3)
        else $error("count word identifier wrong");
    AST_ODD_PARITY: assert property ((seq_count_read or seq_low_read) |=> (^o_rd_data) == 1'b1)
        else $error("result word parity not odd");
    AST_EIGHTH_FIELD: assert property (seq_count_read and i_eighth_turn_resolution
        |=> o_rd_data[11:0] == $past(pos_ff[20:9]))
        else $error("eighth-turn count field mismatch");
    AST_HELD_AFTER_COUNT: assert property (seq_count_read ##1 seq_low_read |=> o_rd_data[14] == 1'b1
        && o_rd_data[10:0] == $past(held_low_ff))
        else $error("low word not held after count read");
    AST_HELD_CLEARS: assert property (seq_low_read |=> !held_ff)
        else $error("held bit not cleared by low word read");
    AST_OVF_STICKY: assert property (overflow_ff && !i_warn_clear |=> overflow_ff)
        else $error("overflow flag dropped without clear");
    AST_WARN_ON_TICK: assert property ($rose(step_warn_ff) |-> $past(tick))
        else $error("step warning rose outside an update");
    AST_FINE_TOP_ZERO: assert property (i_rd_en && i_rd_addr == FINE_ANGLE_WORD_ADDR
        |=> o_rd_data[15] == 1'b0 && o_rd_data[14:0] == $past(i_fine_angle))
        else $error("fine angle word wrong");
    AST_FAULT_BIT: assert property (i_rd_en && i_rd_addr == DAMPED_ANGLE_WORD_ADDR
        |=> o_rd_data[14] == $past(unmasked_fault_flag) && o_rd_data[13] == $past(supply_low_flag))
        else $error("fault or supply bit wrong in angle word");
    AST_HELD_SETS: assert property (seq_count_read |=> held_ff)
        else $error("held bit not set by count read");
    // Host reads are spaced, so the back-to-back case above is never driven; this one covers any spacing
    AST_HELD_SNAPSHOT: assert property (held_ff ##0 seq_low_read |=> o_rd_data[14] == 1'b1
        && o_rd_data[10:0] == $past(held_low_ff))
        else $error("held low bits not returned");
    AST_LIVE_LOW: assert property (!held_ff ##0 seq_low_read |=> o_rd_data[14] == 1'b0
        && o_rd_data[10:0] == $past(low_field))
        else $error("live low bits not returned");
    AST_LOW_ID: assert property (seq_low_read |=> o_rd_data[15] == 1'b1 && o_rd_data[13] == 1'b0)
        else $error("low word identifier wrong");
    AST_HALF_FIELD: assert property (seq_count_read and !i_eighth_turn_resolution
        |=> o_rd_data[11:0] == $past({{2{pos_ff[20]}}, pos_ff[20:11]}))
        else $error("half-turn count field mismatch");
    AST_LP_WORD: assert property (i_rd_en && i_rd_addr == LOW_POWER_ANGLE_WORD_ADDR
        |=> o_rd_data[11:0] == $past(i_low_power_path_angle) && o_rd_data[13] == $past(supply_low_flag))
        else $error("low-power angle word wrong");

endmodule

// ### verif/tca_host_model.sv
// Host model that reads result words and clears latched warnings
`timescale 1ns/1ps

module tca_host_model (
    input wire logic i_core_clk,       // Core clock
    output logic o_rd_en,              // Read strobe
    output logic [7:0] o_rd_addr,      // Read offset
    input wire logic [15:0] i_rd_data, // Returned word
    input wire logic i_rd_valid,       // Returned word valid
    output logic o_warn_clear          // Clears latched warnings
);
    initial begin
        o_rd_en = 1'b0;
        o_rd_addr = 8'h00;
        o_warn_clear = 1'b0;
    end

    // One strobe per read; the answer must come within four edges
    task automatic read_word(input logic [7:0] addr, output logic [15:0] data, output bit ok);
        ok = 1'b0;
        data = 16'h0000;
        @(posedge i_core_clk);
        o_rd_en <= 1'b1;
        o_rd_addr <= addr;
        @(posedge i_core_clk);
        o_rd_en <= 1'b0;
        // Released address is scrambled so a stale decode cannot pass
        o_rd_addr <= ~addr;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge i_core_clk);
            if (i_rd_valid === 1'b1) begin
                data = i_rd_data;
                ok = 1'b1;
            end
        end
    endtask

    task automatic clear_warnings();
        @(posedge i_core_clk);
        o_warn_clear <= 1'b1;
        @(posedge i_core_clk);
        o_warn_clear <= 1'b0;
    endtask
endmodule

// ### verif/tca_readout_tb_top.sv
// Self-checking bench for the turns counter and angle readout block
`timescale 1ns/1ps

module tca_readout_tb_top
    import tca_pkg::*;
;
    localparam int TP = 8;
    localparam int MAX_POS = 1048575;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic rd_en, rd_valid, warn_clear, ovf, stp, fault, sup_low;
    logic [7:0] rd_addr;
    logic [15:0] rd_data, got;
    logic [ANGLE_W-1:0] damped = 12'hABC;
    logic [ANGLE_W-1:0] lp = 12'h123;
    logic [FINE_W-1:0] fine = 15'h5A5B;
    logic src = 1'b1, eighth = 1'b1, other = 1'b0, ovf_m = 1'b0, stp_m = 1'b0;
    logic sup_a = 1'b0, sup_d = 1'b0, sup_a_m = 1'b0, sup_d_m = 1'b0;
    int n_mismatch = 0;
    int compares = 0;
    int pos = 0;
    bit ok;

    always #4 i_core_clk = ~i_core_clk;

    tca_readout #(.TURN_PERIOD(TP)) u_dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_damped_angle(damped), .i_fine_angle(fine),
        .i_low_power_path_angle(lp), .i_rotation_source_select(src), .i_eighth_turn_resolution(eighth),
        .i_other_fault(other), .i_overflow_mask(ovf_m), .i_step_warn_mask(stp_m),
        .i_analog_supply_low(sup_a), .i_core_supply_low(sup_d), .i_analog_mask(sup_a_m), .i_core_mask(sup_d_m),
        .i_warn_clear(warn_clear), .o_rotation_overflow_flag(ovf), .o_turns_step_warning(stp),
        .o_unmasked_fault_flag(fault), .o_supply_low_flag(sup_low));

    tca_host_model u_host (
        .i_core_clk(i_core_clk), .o_rd_en(rd_en), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid), .o_warn_clear(warn_clear));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [15:0] odd(input logic [15:0] w);
        return (^w) ? w : (w | 16'h1000);
    endfunction

    function automatic logic [15:0] cnt_word();
        logic [20:0] p;
        p = pos[20:0];
        return odd({2'b11, src, 1'b0, (eighth ? p[20:9] : {{2{p[20]}}, p[20:11]})});
    endfunction

    function automatic logic [15:0] low_word(input logic held, input int pv);
        logic [20:0] p;
        p = pv[20:0];
        return odd({1'b1, held, 3'b000, (eighth ? {2'b00, p[8:0]} : p[10:0])});
    endfunction

    function automatic logic [15:0] ang_word(input logic [11:0] a, input logic f, input logic u);
        return odd({1'b0, f, u, 1'b0, a});
    endfunction

    task automatic rd(input logic [7:0] a);
        u_host.read_word(a, got, ok);
        if (!ok) begin
            n_mismatch++;
            close_out();
        end
    endtask

    // Aligns both angle inputs first so a source change adds no false step
    task automatic set_mode(input logic s, input logic e);
        @(posedge i_core_clk);
        if (src) lp <= damped;
        else damped <= lp;
        @(posedge i_core_clk);
        src <= s;
        eighth <= e;
        repeat (3 * TP) @(posedge i_core_clk);
    endtask

    task automatic move(input int step, input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            if (src) damped <= damped + step[11:0];
            else lp <= lp + step[11:0];
            pos += step;
            repeat (3 * TP) @(posedge i_core_clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_words();
        check({14'h0, stp, ovf}, 16'h0000);
        rd(FINE_ANGLE_WORD_ADDR);
        check(got, {1'b0, fine});
        rd(DAMPED_ANGLE_WORD_ADDR);
        check(got, ang_word(damped, 1'b0, 1'b0));
        rd(8'h36);
        check(got, 16'h0000);
        rd(8'h2D);
        check(got, 16'h0000);
    endtask

    task automatic sc_turns();
        for (int m = 0; m < 4; m++) begin
            set_mode(m[1], ~m[0]);
            move(1535, 3);
            rd(ROTATION_COUNT_WORD_ADDR);
            check(got, cnt_word());
            move(-1535, 9);
            rd(ROTATION_COUNT_WORD_ADDR);
            check(got, cnt_word());
            rd(POSITION_LOW_BITS_WORD_ADDR);
            check(got, low_word(1'b1, pos));
        end
    endtask

    task automatic sc_snapshot();
        int held;
        rd(POSITION_LOW_BITS_WORD_ADDR);
        check(got, low_word(1'b0, pos));
        rd(ROTATION_COUNT_WORD_ADDR);
        held = pos;
        move(777, 1);
        rd(POSITION_LOW_BITS_WORD_ADDR);
        check(got, low_word(1'b1, held));
        rd(POSITION_LOW_BITS_WORD_ADDR);
        check(got, low_word(1'b0, pos));
    endtask

    task automatic sc_flags();
        logic u;
        for (int i = 0; i < 17; i++) begin
            @(posedge i_core_clk);
            {sup_a, sup_d, sup_a_m, sup_d_m} <= i[3:0];
            other <= i[0] ^ i[2];
            repeat (4) @(posedge i_core_clk);
            u = (sup_a & ~sup_a_m) | (sup_d & ~sup_d_m);
            check({14'h0, fault, sup_low}, {14'h0, other, u});
            rd(LOW_POWER_ANGLE_WORD_ADDR);
            check(got, ang_word(lp, other, u));
        end
    endtask

    task automatic sc_step();
        move(1537, 1);
        check({14'h0, stp, fault}, 16'h0003);
        @(posedge i_core_clk);
        stp_m <= 1'b1;
        @(posedge i_core_clk);
        check({15'h0, fault}, 16'h0000);
        u_host.clear_warnings();
        @(posedge i_core_clk);
        stp_m <= 1'b0;
        check({15'h0, stp}, 16'h0000);
    endtask

    task automatic sc_overflow();
        set_mode(1'b1, 1'b1);
        while (pos + 1535 <= MAX_POS) move(1535, 1);
        rd(ROTATION_COUNT_WORD_ADDR);
        check(got, cnt_word());
        check({15'h0, ovf}, 16'h0000);
        // Overflow holds the last position, so the expected position stays put
        move(1535, 1);
        pos -= 1535;
        rd(ROTATION_COUNT_WORD_ADDR);
        check(got, cnt_word());
        check({14'h0, ovf, fault}, 16'h0003);
        @(posedge i_core_clk);
        ovf_m <= 1'b1;
        @(posedge i_core_clk);
        check({15'h0, fault}, 16'h0000);
        u_host.clear_warnings();
        @(posedge i_core_clk);
        check({15'h0, ovf}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        // First turns update after reset only takes the reference angle
        repeat (3 * TP) @(posedge i_core_clk);
        sc_words();
        sc_turns();
        sc_snapshot();
        sc_flags();
        sc_step();
        sc_overflow();
        close_out();
    end
endmodule
